// *** verilog/termination_control.sv ***
// on-die termination control: on/off, strength, power-down timing modes
`timescale 1ns/1ps
`default_nettype none

module termination_control #(
  parameter logic [5:0] CPDED_CYCLES = term_pkg::CPDED_DEFAULT,
  parameter logic [5:0] XPDLL_CYCLES = term_pkg::XPDLL_DEFAULT,
  parameter logic [5:0] RFC_CYCLES = term_pkg::RFC_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic mem_clk,
  input wire term_pkg::pins_t pins,
  input wire term_pkg::mode_t mode,
  output var term_pkg::term_out_t term,
  output var logic hold_error
);

  localparam int W = term_pkg::CNT_W;
  localparam int D = term_pkg::LINE_DEPTH;

  // ---------------------------------------------------------------------------
  // pin sampling and device clock edge
  // ---------------------------------------------------------------------------
  logic [term_pkg::PIN_W-1:0] sync_vec;
  term_pkg::pins_t pin_s;
  logic ck_s;
  logic ck_prev_q, ck_prev_d;
  logic cke_last_q, cke_last_d;
  logic term_in_last_q, term_in_last_d;
  logic tick;

  pin_sync #(.WIDTH(term_pkg::PIN_W)) u_pin_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .d_async({mem_clk, pins}),
    .q_sync(sync_vec)
  );

  assign {ck_s, pin_s} = sync_vec;
  // every latency below advances only on a device clock rising edge
  assign tick = clk_en & ck_s & ~ck_prev_q;

  always_comb begin
    ck_prev_d = clk_en ? ck_s : ck_prev_q;
    cke_last_d = tick ? pin_s.cke : cke_last_q;
    term_in_last_d = tick ? pin_s.termination_input : term_in_last_q;
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ck_prev_q <= 1'b0;
      cke_last_q <= 1'b0;
      term_in_last_q <= 1'b0;
    end else begin
      ck_prev_q <= ck_prev_d;
      cke_last_q <= cke_last_d;
      term_in_last_q <= term_in_last_d;
    end
  end

  // ---------------------------------------------------------------------------
  // latencies and mode decode
  // ---------------------------------------------------------------------------
  localparam int IDX_W_L = term_pkg::IDX_W;
  logic [W-1:0] write_lat;
  logic [W-1:0] lat;
  logic [IDX_W_L-1:0] tap;
  logic dyn_en;
  logic term_en;
  logic enable;

  assign write_lat = {1'b0, mode.cas_write_latency} + {1'b0, mode.additive_latency};
  assign lat = write_lat - term_pkg::LAT_OFFSET;
  // the sample registered lat ticks ago sits at index lat
  assign tap = IDX_W_L'(lat);
  // dll-off operation relies on the controller clearing the write strength first
  assign dyn_en = |mode.rtt_wr;
  assign term_en = (|mode.rtt_nom) | (|mode.rtt_wr);
  assign enable = term_en & ~pin_s.self_refresh;

  // ---------------------------------------------------------------------------
  // termination input delay line with window marks
  // ---------------------------------------------------------------------------
  logic [D-1:0] line_q, line_d;
  logic [D-1:0] unc_q, unc_d;
  logic entry_evt, exit_evt, mark_evt, win_now;
  logic [W-1:0] lead_lim;
  term_pkg::timing_mode_t state_q, state_d;

  // entry lead excludes its own start point, exit lead includes it
  assign lead_lim = entry_evt ? (write_lat - term_pkg::LEAD_OFFSET) : write_lat;
  assign mark_evt = entry_evt | exit_evt;
  assign win_now = mark_evt | (state_q == term_pkg::MODE_WINDOW);

  genvar i;
  generate
    for (i = 0; i < D; i++) begin : g_line
      if (i == 0) begin : g_head
        assign line_d[i] = tick ? pin_s.termination_input : line_q[i];
        assign unc_d[i] = tick ? win_now : unc_q[i];
      end else begin : g_body
        assign line_d[i] = tick ? line_q[i-1] : line_q[i];
        // samples taken during the lead are relabelled once cke shows the change
        assign unc_d[i] = tick ? (unc_q[i-1] | (mark_evt && (W'(i) < lead_lim))) : unc_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      line_q <= '0;
      unc_q <= '0;
    end else begin
      line_q <= line_d;
      unc_q <= unc_d;
    end
  end

  // ---------------------------------------------------------------------------
  // dynamic strength after writes
  // ---------------------------------------------------------------------------
  logic wr_act_q, wr_act_d;
  logic [W-1:0] wr_cnt_q, wr_cnt_d;
  logic chop_q, chop_d;
  logic wsel_q, wsel_d;
  logic [W-1:0] cwn;
  logic [W-1:0] wr_next;

  assign wr_next = wr_cnt_q + term_pkg::CNT_ONE;
  assign cwn = lat + (chop_q ? term_pkg::CWN_CHOP_EXTRA : term_pkg::CWN_FULL_EXTRA);

  always_comb begin
    wr_act_d = wr_act_q;
    wr_cnt_d = wr_cnt_q;
    chop_d = chop_q;
    wsel_d = wsel_q;
    if (tick) begin
      if (pin_s.write_cmd && dyn_en) begin
        // the pending write still applies its switch point due on this tick
        if (wr_act_q && wr_next == lat) begin
          wsel_d = 1'b1;
        end
        if (wr_act_q && wr_next == cwn) begin
          wsel_d = 1'b0;
        end
        // a new write restarts the count, so back-to-back bursts stay on write strength
        wr_act_d = 1'b1;
        wr_cnt_d = term_pkg::CNT_ZERO;
        chop_d = mode.chop_otf_en ? pin_s.write_chop : mode.chop_fixed;
      end else if (wr_act_q) begin
        wr_cnt_d = wr_cnt_q + term_pkg::CNT_ONE;
        if (wr_cnt_d == lat) begin
          wsel_d = 1'b1;
        end
        if (wr_cnt_d == cwn) begin
          wsel_d = 1'b0;
          wr_act_d = 1'b0;
        end
      end
    end
    if (clk_en && !dyn_en) begin
      wr_act_d = 1'b0;
      wsel_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wr_act_q <= 1'b0;
      wr_cnt_q <= '0;
      chop_q <= 1'b0;
      wsel_q <= 1'b0;
    end else begin
      wr_act_q <= wr_act_d;
      wr_cnt_q <= wr_cnt_d;
      chop_q <= chop_d;
      wsel_q <= wsel_d;
    end
  end

  // ---------------------------------------------------------------------------
  // timing mode and transition windows
  // ---------------------------------------------------------------------------
  logic [W-1:0] win_cnt_q, win_cnt_d;
  logic [W-1:0] rfc_q, rfc_d;
  logic [W-1:0] entry_len, load_len;

  // only a frozen dll in precharge power-down goes asynchronous
  assign entry_evt = tick & cke_last_q & ~pin_s.cke & ~mode.pd_dll_fast
                     & pin_s.banks_idle;
  assign exit_evt = tick & ~cke_last_q & pin_s.cke & (state_q != term_pkg::MODE_SYNC);
  assign entry_len = (rfc_q > CPDED_CYCLES) ? rfc_q : CPDED_CYCLES;
  assign load_len = (entry_evt ? entry_len : XPDLL_CYCLES) - term_pkg::CNT_ONE;

  always_comb begin
    win_cnt_d = win_cnt_q;
    rfc_d = rfc_q;
    state_d = state_q;
    if (tick) begin
      if (pin_s.refresh_cmd) begin
        rfc_d = RFC_CYCLES;
      end else if (rfc_q != term_pkg::CNT_ZERO) begin
        rfc_d = rfc_q - term_pkg::CNT_ONE;
      end
      if (mark_evt) begin
        // keep the later end so overlapping windows merge into one
        win_cnt_d = (win_cnt_q > load_len) ? win_cnt_q : load_len;
      end else if (win_cnt_q != term_pkg::CNT_ZERO) begin
        win_cnt_d = win_cnt_q - term_pkg::CNT_ONE;
      end
      case (state_q)
        term_pkg::MODE_SYNC: begin
          if (entry_evt) begin
            state_d = term_pkg::MODE_WINDOW;
          end
        end
        term_pkg::MODE_WINDOW: begin
          if (!mark_evt && win_cnt_q == term_pkg::CNT_ZERO) begin
            state_d = pin_s.cke ? term_pkg::MODE_SYNC : term_pkg::MODE_ASYNC;
          end
        end
        term_pkg::MODE_ASYNC: begin
          if (exit_evt) begin
            state_d = term_pkg::MODE_WINDOW;
          end
        end
        default: begin
          state_d = term_pkg::MODE_SYNC;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      win_cnt_q <= '0;
      rfc_q <= '0;
      state_q <= term_pkg::MODE_SYNC;
    end else begin
      win_cnt_q <= win_cnt_d;
      rfc_q <= rfc_d;
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // controller hold-time monitor
  // ---------------------------------------------------------------------------
  logic [W-1:0] hold_cnt_q, hold_cnt_d;
  logic [W-1:0] need_q, need_d;
  logic herr_q, herr_d;

  always_comb begin
    hold_cnt_d = hold_cnt_q;
    need_d = need_q;
    herr_d = herr_q;
    if (tick) begin
      if (pin_s.termination_input) begin
        if (!term_in_last_q) begin
          hold_cnt_d = term_pkg::CNT_ONE;
          need_d = term_pkg::HOLD_SHORT;
        end else if (hold_cnt_q != term_pkg::CNT_MAX) begin
          hold_cnt_d = hold_cnt_q + term_pkg::CNT_ONE;
        end
        if (pin_s.write_cmd) begin
          hold_cnt_d = term_pkg::CNT_ONE;
          need_d = (mode.chop_otf_en ? pin_s.write_chop : mode.chop_fixed)
                   ? term_pkg::HOLD_SHORT : term_pkg::HOLD_LONG;
        end
      end else if (term_in_last_q && hold_cnt_q < need_q) begin
        herr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      hold_cnt_q <= '0;
      need_q <= '0;
      herr_q <= 1'b0;
    end else begin
      hold_cnt_q <= hold_cnt_d;
      need_q <= need_d;
      herr_q <= herr_d;
    end
  end

  assign hold_error = herr_q;

  // ---------------------------------------------------------------------------
  // termination outputs
  // ---------------------------------------------------------------------------
  term_pkg::term_out_t term_q, term_d;
  logic sync_val, async_val;

  assign sync_val = line_q[tap];
  assign async_val = pin_s.termination_input;

  always_comb begin
    term_d = term_q;
    if (clk_en) begin
      term_d.on = enable & ((state_q == term_pkg::MODE_ASYNC) ? async_val : sync_val);
      term_d.write_sel = wsel_q;
      term_d.strength = wsel_q ? {1'b0, mode.rtt_wr} : mode.rtt_nom;
      // the synchronous answer is shown outside async mode; uncertain marks where sync and async differ in window mode or on a lead-marked sample
      term_d.uncertain = enable & ((state_q == term_pkg::MODE_WINDOW) | unc_q[tap])
                         & (sync_val ^ async_val);
      term_d.async_mode = (state_q == term_pkg::MODE_ASYNC);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      term_q <= '0;
    end else begin
      term_q <= term_d;
    end
  end

  assign term = term_q;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  selfref_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && pin_s.self_refresh) |=> !term.on)
    else $error("termination on during self-refresh");

  dyn_off_nom_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && !dyn_en && $past(clk_en && !dyn_en)) |=> !term.write_sel)
    else $error("write strength selected with switching off");

  strength_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en |=> term.strength == (term.write_sel ? {1'b0, $past(mode.rtt_wr)}
                                                : $past(mode.rtt_nom)))
    else $error("wrong termination strength code");

  write_sel_on_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(wsel_q) |-> $past(wr_act_q) && ($past(wr_cnt_q) + term_pkg::CNT_ONE == lat))
    else $error("write strength selected at wrong latency");

  write_sel_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    ($fell(wsel_q) && dyn_en) |-> ($past(wr_cnt_q) + term_pkg::CNT_ONE == $past(cwn)))
    else $error("nominal strength restored at wrong latency");

  async_direct_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && state_q == term_pkg::MODE_ASYNC && enable) |=> term.on == $past(async_val))
    else $error("asynchronous termination not following input");

  sync_tap_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && state_q != term_pkg::MODE_ASYNC && enable) |=> term.on == $past(sync_val))
    else $error("synchronous termination not delayed by latency");

  entry_window_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (entry_evt && state_q == term_pkg::MODE_SYNC) |=> state_q == term_pkg::MODE_WINDOW)
    else $error("power-down entry did not open window");

  entry_len_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (entry_evt && win_cnt_q == term_pkg::CNT_ZERO)
      |=> win_cnt_q == ($past(entry_len) - term_pkg::CNT_ONE))
    else $error("entry window length wrong");

  uncertain_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $rose(term.uncertain) |-> $past(state_q == term_pkg::MODE_WINDOW || unc_q[tap]))
    else $error("uncertain flag outside a transition window");

endmodule

`default_nettype wire

// *** pkg/term_pkg.sv ***
// shared constants, carriers and states of the termination control block
package term_pkg;

  // ---------------------------------------------------------------------------
  // structure sizes
  // ---------------------------------------------------------------------------
  localparam int LINE_DEPTH = 32;
  localparam int IDX_W = 5;
  localparam int CNT_W = 6;

  // ---------------------------------------------------------------------------
  // latencies in device clock cycles
  // ---------------------------------------------------------------------------
  // turn-on, turn-off and nominal_to_write_latency are all write_latency minus this
  localparam logic [CNT_W-1:0] LAT_OFFSET = 6'h02;
  // write_to_nominal_latency_chop = 4 + termination_off_latency
  localparam logic [CNT_W-1:0] CWN_CHOP_EXTRA = 6'h04;
  // write_to_nominal_latency_full = 6 + termination_off_latency
  localparam logic [CNT_W-1:0] CWN_FULL_EXTRA = 6'h06;
  // min_high_hold_short and min_high_hold_long
  localparam logic [CNT_W-1:0] HOLD_SHORT = 6'h04;
  localparam logic [CNT_W-1:0] HOLD_LONG = 6'h06;
  // pd_window_lead_time is write_latency minus this
  localparam logic [CNT_W-1:0] LEAD_OFFSET = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_MAX = 6'h3f;

  // defaults for delays given in device cycles
  localparam logic [CNT_W-1:0] CPDED_DEFAULT = 6'h01;
  localparam logic [CNT_W-1:0] XPDLL_DEFAULT = 6'h0a;
  localparam logic [CNT_W-1:0] RFC_DEFAULT = 6'h14;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  // pins sampled from the controller, all outside the clk_sys domain
  typedef struct packed {
    logic termination_input;
    logic cke;
    logic write_cmd;
    logic write_chop;
    logic refresh_cmd;
    logic self_refresh;
    logic banks_idle;
  } pins_t;

  localparam int PIN_W = $bits(pins_t) + 1;

  // mode register fields, held static by the mode register logic
  typedef struct packed {
    logic [2:0] rtt_nom;
    logic [1:0] rtt_wr;
    logic pd_dll_fast;
    logic chop_fixed;
    logic chop_otf_en;
    logic [4:0] cas_write_latency;
    logic [4:0] additive_latency;
  } mode_t;

  typedef struct packed {
    logic on;
    logic write_sel;
    logic [2:0] strength;
    logic uncertain;
    logic async_mode;
  } term_out_t;

  typedef enum logic [1:0] {
    MODE_SYNC = 2'b00,
    MODE_WINDOW = 2'b01,
    MODE_ASYNC = 2'b11
  } timing_mode_t;

endpackage

// *** verilog/pin_sync.sv ***
// two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] d_async,
  output var logic [WIDTH-1:0] q_sync
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic meta_d;
      logic sync_q;
      logic sync_d;
      always_comb begin
        meta_d = clk_en ? d_async[i] : meta_q;
        sync_d = clk_en ? meta_q : sync_q;
      end
      always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= meta_d;
          sync_q <= sync_d;
        end
      end
      assign q_sync[i] = sync_q;
    end
  endgenerate

endmodule

`default_nettype wire

// *** tb/ctrl_model.sv ***
// controller-side model: free-running device clock and command/termination pins
`timescale 1ns/1ps
`default_nettype none

module ctrl_model (
  input wire logic clk_sys,
  output var logic mem_clk,
  output var term_pkg::pins_t pins
);
  // ------------------------------------------------------------
  // device clock
  // ------------------------------------------------------------
  // the clock must stay stable in power-down, so it never stops
  initial begin
    mem_clk = 1'h0;
    #7;
    forever #80 mem_clk = ~mem_clk;
  end

  // ------------------------------------------------------------
  // pin driver
  // ------------------------------------------------------------
  logic break_hold;
  int cnt;
  int need;

  initial begin
    pins = '0;
    break_hold = 1'h0;
    cnt = 0;
    need = 0;
  end

  // pins move mid-cycle so they are settled around each rising edge
  task automatic step(input term_pkg::pins_t p, output term_pkg::pins_t sent);
    @(negedge mem_clk);
    repeat (3) @(posedge clk_sys);
    #1;
    // an early release is only sent when a test asks for it
    if (!p.termination_input && pins.termination_input && cnt + 1 < need && !break_hold) begin
      p.termination_input = 1'h1;
    end
    if (p.termination_input && (!pins.termination_input || p.write_cmd)) begin
      cnt = 0;
      need = (p.write_cmd && !p.write_chop) ? 6 : 4;
    end else begin
      cnt = cnt + 1;
    end
    pins = p;
    sent = p;
  endtask
endmodule
`default_nettype wire

// *** tb/termination_control_bench.sv ***
// self-checking bench for the termination control block
`timescale 1ns/1ps
`default_nettype none

module termination_control_bench;
  // ------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------
  localparam logic [5:0] RFC = 6'h06;
  logic clk_sys;
  logic reset_n;
  logic clk_en;
  logic mem_clk;
  logic hold_error;
  logic chk_on;
  logic unc_seen;
  term_pkg::pins_t pins;
  term_pkg::pins_t sent;
  term_pkg::mode_t mode;
  term_pkg::term_out_t term;
  int n_errors;
  int check_count;
  int cycles;
  int k;
  int lat;
  logic [3:0] hist [0:4095];

  termination_control #(.CPDED_CYCLES(6'h01), .XPDLL_CYCLES(6'h04), .RFC_CYCLES(RFC))
    u_termination_control (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .mem_clk(mem_clk), .pins(pins), .mode(mode), .term(term), .hold_error(hold_error));

  ctrl_model u_ctrl_model (.clk_sys(clk_sys), .mem_clk(mem_clk), .pins(pins));

  initial begin
    clk_sys = 1'h0;
    forever #10 clk_sys = ~clk_sys;
  end

  // about 4000 cycles are needed; the ceiling leaves ample slack
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (term.uncertain === 1'h1) unc_seen = 1'h1;
    if (cycles == 20000) begin
      n_errors = n_errors + 1;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      n_errors = n_errors + 1;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // code bits: termination input, write, chop, cke
  function automatic term_pkg::pins_t mk(input logic [3:0] c);
    term_pkg::pins_t r;
    r = '0;
    {r.termination_input, r.write_cmd, r.write_chop, r.cke} = c;
    r.banks_idle = 1'h1;
    return r;
  endfunction

  // expected synchronous outputs for tick t, from the pin history
  task automatic ref_check(input int t);
    logic on;
    logic sel;
    on = (t >= lat) ? hist[t-lat][3] : 1'h0;
    if (hist[t][0] || (mode.rtt_nom == 3'h0 && mode.rtt_wr == 2'h0)) on = 1'h0;
    sel = 1'h0;
    for (int d = lat + 5; d >= lat; d--) begin
      if (t >= d && hist[t-d][2]) sel = (d < lat + (hist[t-d][1] ? 4 : 6));
    end
    if (mode.rtt_wr == 2'h0) sel = 1'h0;
    check(term.on, on);
    check(term.write_sel, sel);
    check(term.strength, sel ? {1'h0, mode.rtt_wr} : mode.rtt_nom);
    check(term.uncertain, 1'h0);
  endtask

  task automatic run(input term_pkg::pins_t q, input int n);
    repeat (n) begin
      u_ctrl_model.step(q, sent);
      // the burst kind follows the mode register unless chosen on the fly
      hist[k] = {sent.termination_input, sent.write_cmd,
                 mode.chop_otf_en ? sent.write_chop : mode.chop_fixed, sent.self_refresh};
      if (chk_on && k > 0) ref_check(k - 1);
      k = k + 1;
    end
  endtask

  task automatic set_mode(input logic [4:0] cwl, add_lat, input logic [2:0] nom,
                          input logic [1:0] wr, input logic fast);
    chk_on = 1'h0;
    run(mk(4'h1), 2);
    mode = '{nom, wr, fast, 1'h0, 1'h1, cwl, add_lat};
    lat = cwl + add_lat - 2;
    run(mk(4'h1), lat + 8);
    chk_on = 1'h1;
  endtask

  task automatic do_reset();
    @(posedge clk_sys);
    #1;
    reset_n = 1'h0;
    repeat (8) @(posedge clk_sys);
    #1;
    reset_n = 1'h1;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic pulse();
    run(mk(4'h9), 1);
    run(mk(4'h1), 8);
  endtask

  task automatic t_sync();
    term_pkg::pins_t p;
    set_mode(5'h05, 5'h00, 3'h1, 2'h0, 1'h1);
    pulse();
    set_mode(5'h05, 5'h02, 3'h4, 2'h0, 1'h1);
    pulse();
    set_mode(5'h06, 5'h00, 3'h0, 2'h0, 1'h1);
    pulse();
    set_mode(5'h05, 5'h00, 3'h2, 2'h0, 1'h1);
    p = mk(4'h9);
    p.self_refresh = 1'h1;
    run(p, 8);
    p.termination_input = 1'h0;
    run(p, 6);
    run(mk(4'h1), 4);
    $display("test sync done");
  endtask

  // full write then a chop write while the first is still pending
  task automatic t_dyn();
    for (int w = 0; w < 4; w++) begin
      set_mode(5'h06, 5'h00, 3'h2, w[1:0], 1'h1);
      run(mk(4'h9), 2);
      run(mk(4'hd), 1);
      run(mk(4'h9), 3);
      run(mk(4'hf), 1);
      run(mk(4'h1), 12);
      run(mk(4'h5), 1);
      run(mk(4'h1), 12);
    end
    // burst chop fixed by mode register, the write's own chop bit left low
    set_mode(5'h06, 5'h00, 3'h2, 2'h1, 1'h1);
    mode.chop_fixed = 1'h1;
    mode.chop_otf_en = 1'h0;
    run(mk(4'h5), 1);
    run(mk(4'h1), 12);
    check(hold_error, 1'h0);
    $display("test dyn done");
  endtask

  task automatic pd_entry(input logic rf, input logic ti);
    term_pkg::pins_t p;
    // the dll stops in this power-down, so the write strength is programmed off first
    set_mode(5'h05, 5'h02, 3'h3, 2'h0, 1'h0);
    chk_on = 1'h0;
    p = mk({ti, 3'h1});
    p.refresh_cmd = rf;
    run(p, 1);
    run(mk({ti, 3'h0}), 5);
    check(term.async_mode, !rf);
    if (ti) check(term.on, 1'h1);
    run(mk({ti, 3'h0}), 4);
    check(term.async_mode, 1'h1);
    run(mk(4'h1), 8);
    check(term.async_mode, 1'h0);
    check(term.on, 1'h0);
  endtask

  task automatic t_pd();
    term_pkg::pins_t p;
    unc_seen = 1'h0;
    pd_entry(1'h0, 1'h1);
    check(unc_seen, 1'h1);
    pd_entry(1'h1, 1'h0);
    set_mode(5'h05, 5'h02, 3'h3, 2'h0, 1'h1);
    chk_on = 1'h0;
    run(mk(4'h0), 8);
    check(term.async_mode, 1'h0);
    run(mk(4'h1), 8);
    // active power-down keeps synchronous timing even with a frozen dll
    set_mode(5'h05, 5'h02, 3'h3, 2'h0, 1'h0);
    chk_on = 1'h0;
    p = mk(4'h0);
    p.banks_idle = 1'h0;
    run(p, 8);
    check(term.async_mode, 1'h0);
    run(mk(4'h1), 8);
    $display("test pd done");
  endtask

  task automatic t_hold();
    set_mode(5'h05, 5'h00, 3'h1, 2'h0, 1'h1);
    chk_on = 1'h0;
    u_ctrl_model.break_hold = 1'h1;
    run(mk(4'h9), 3);
    run(mk(4'h1), 3);
    check(hold_error, 1'h1);
    do_reset();
    check(hold_error, 1'h0);
    run(mk(4'h9), 5);
    run(mk(4'hd), 1);
    run(mk(4'h9), 3);
    run(mk(4'h1), 3);
    check(hold_error, 1'h1);
    do_reset();
    u_ctrl_model.break_hold = 1'h0;
    $display("test hold done");
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    mode = '{3'h0, 2'h0, 1'h1, 1'h0, 1'h1, 5'h05, 5'h00};
    chk_on = 1'h0;
    unc_seen = 1'h0;
    n_errors = 0;
    check_count = 0;
    cycles = 0;
    k = 0;
    lat = 3;
    do_reset();
    t_sync();
    t_dyn();
    t_pd();
    t_hold();
    conclude();
  end
endmodule
`default_nettype wire
